// ===== include/dmap_consts.svh
// offsets, field positions, codes for the diagnostic memory access port
`ifndef DMAP_CONSTS_SVH
`define DMAP_CONSTS_SVH
`define DMAP_OFS_ADDR    8'h00
`define DMAP_OFS_DATA    8'h08
`define DMAP_OFS_RDDATA  8'h10
`define DMAP_OFS_WRDATA  8'h18
`define DMAP_OFS_RDECC   8'h20
`define DMAP_OFS_WRECC   8'h28
`define DMAP_OFS_INIT    8'h30
`define DMAP_OFS_SCRUB   8'h38
`define DMAP_OFS_ERRINFO 8'h40
`define DMAP_LW_LSB      3
`define DMAP_PGO_LSB     5
`define DMAP_PGO_W       21
`define DMAP_BANK_LSB    26
`define DMAP_ROW_LSB     31
`define DMAP_ADDR_MASK   64'h0000_0003_8fff_fff8
`define DMAP_ADDR_RST    64'h0000_0000_0000_0000
`define DMAP_DATA_RST    64'h0000_0000_0000_0000
`define DMAP_EC_NONE     5'h00
`define DMAP_EC_SBE      5'h01
`define DMAP_EC_DBE      5'h02
`define DMAP_EC_APAR     5'h03
`define DMAP_EC_UNMAP    5'h04
`endif

// ===== include/dmap_pkg.sv
// types of the diagnostic memory access port
package dmap_pkg;
  typedef enum logic [1:0] {
    SEV_NONE = 2'h0,
    SEV_ADV  = 2'h1,
    SEV_SOFT = 2'h2,
    SEV_HARD = 2'h3
  } dmap_sev_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EXEC = 3'h2,
    ST_DONE = 3'h4
  } dmap_state_t;
  typedef struct packed {
    logic        write;
    logic [7:0]  offset;
    logic [63:0] wdata;
    logic        apar;
  } dmap_req_t;
  typedef struct packed {
    logic        valid;
    logic        err;
    logic [2:0]  chip;
    logic [4:0]  code;
    logic [63:0] data;
  } dmap_rsp_t;
  typedef struct packed {
    logic        sbe;
    logic        dbe;
    logic [63:0] d;
  } dmap_dec_t;
endpackage

// ===== src/dmap_top.sv
// diagnostic memory access port with line store and error logging
`timescale 1ns/10ps
`default_nettype none
`include "dmap_consts.svh"
module dmap_top #(
  parameter int         LINES   = 64,
  parameter logic [2:0] CHIP_ID = 3'h1 // arbitrary value
)(
  input  wire logic              clk_i,     // 50 MHz clock
  input  wire logic              reset_n_i, // sync reset
  input  wire logic              ce_i,      // clock enable
  input  wire logic              csr_valid_i, // request present
  input  wire dmap_pkg::dmap_req_t csr_req_i, // request
  output logic                   csr_ready_o, // request taken
  output dmap_pkg::dmap_rsp_t    csr_rsp_o,   // response
  output logic                   hard_error_o // to utility controller
);
  localparam int LAW = $clog2(LINES);
  generate
    if (LINES < 8 || (LINES & (LINES - 1)) != 0)
    begin : g_bad_lines
      $error("LINES must be a power of two of at least 8");
    end
  endgenerate

  function automatic logic [7:0] ecc_gen(input logic [63:0] d);
    logic [7:0] c;
    logic [7:0] p;
    c = 8'h00;
    p = 8'h03;
    for (int j = 0; j < 64; j++)
    begin
      if (d[j])
        c[6:0] = c[6:0] ^ p[6:0];
      p = p + 8'h01;
      if ((p & (p - 8'h01)) == 8'h00)
        p = p + 8'h01;
    end
    c[7] = ^{d, c[6:0]};
    return c;
  endfunction

  function automatic dmap_pkg::dmap_dec_t ecc_fix(
    input logic [63:0] d,
    input logic [7:0]  e
  );
    dmap_pkg::dmap_dec_t r;
    logic [7:0] s;
    logic [7:0] p;
    logic       ov;
    s = ecc_gen(d) ^ e;
    // overall parity over data and stored code, so a flipped check bit
    // counts as a single error rather than a double one
    ov = ^{d, e};
    r.d = d;
    r.sbe = ov;
    r.dbe = !ov && (s[6:0] != 7'h00);
    p = 8'h03;
    for (int j = 0; j < 64; j++)
    begin
      if (ov && p[6:0] == s[6:0])
        r.d[j] = !d[j];
      p = p + 8'h01;
      if ((p & (p - 8'h01)) == 8'h00)
        p = p + 8'h01;
    end
    return r;
  endfunction

  // line store: four locations per line, one ECC byte each
  logic [63:0] mem_d   [4*LINES];
  logic [7:0]  mem_e   [4*LINES];
  logic [63:0] mem_tag [LINES];

  dmap_pkg::dmap_state_t st;
  dmap_pkg::dmap_req_t   req;
  logic [63:0]           diag_address;
  logic [63:0]           diag_data;
  dmap_pkg::dmap_sev_t   err_sev;
  logic [4:0]            err_code;
  logic                  err_multi;
  logic                  err_over;
  logic                  frozen;

  wire logic exec = ce_i && st == dmap_pkg::ST_EXEC;
  wire logic wr = req.write;
  wire logic [7:0] ofs = req.offset;
  wire logic par_bad = ^{ofs, req.apar};
  wire logic op_rdd = wr && ofs == `DMAP_OFS_RDDATA;
  wire logic op_wrd = wr && ofs == `DMAP_OFS_WRDATA;
  wire logic op_rde = wr && ofs == `DMAP_OFS_RDECC;
  wire logic op_wre = wr && ofs == `DMAP_OFS_WRECC;
  wire logic op_ini = wr && ofs == `DMAP_OFS_INIT;
  wire logic op_scr = wr && ofs == `DMAP_OFS_SCRUB;
  wire logic is_adr = ofs == `DMAP_OFS_ADDR;
  wire logic is_dat = ofs == `DMAP_OFS_DATA;
  wire logic is_err = ofs == `DMAP_OFS_ERRINFO;
  wire logic mapped = is_adr || is_dat || is_err || ofs == `DMAP_OFS_RDDATA
    || ofs == `DMAP_OFS_WRDATA || ofs == `DMAP_OFS_RDECC
    || ofs == `DMAP_OFS_WRECC || ofs == `DMAP_OFS_INIT
    || ofs == `DMAP_OFS_SCRUB;
  wire logic go = exec && !par_bad && mapped;

  // fields at fixed positions, bank taken as given
  wire logic [1:0] lw = diag_address[`DMAP_LW_LSB +: 2];
  wire logic [`DMAP_PGO_W-1:0] pgo = diag_address[`DMAP_PGO_LSB +: `DMAP_PGO_W];
  wire logic [LAW-1:0] line =
    {diag_address[`DMAP_BANK_LSB +: 2], pgo[LAW-3:0]};
  wire logic [LAW+1:0] sel = {line, lw};

  dmap_pkg::dmap_dec_t dec [4];
  logic [3:0] sbe_v;
  logic [3:0] dbe_v;
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_loc
      assign dec[g] = ecc_fix(mem_d[{line, 2'(g)}], mem_e[{line, 2'(g)}]);
      assign sbe_v[g] = dec[g].sbe;
      assign dbe_v[g] = dec[g].dbe;
    end
  endgenerate
  wire dmap_pkg::dmap_dec_t dsel = dec[lw];
  wire logic [7:0] ecc_sel = mem_e[sel];

  // error classification of the operation in progress
  dmap_pkg::dmap_sev_t ev_sev;
  logic [4:0]          ev_code;
  always_comb
  begin
    ev_sev = dmap_pkg::SEV_NONE;
    ev_code = `DMAP_EC_NONE;
    if (par_bad)
    begin
      ev_sev = dmap_pkg::SEV_HARD;
      ev_code = `DMAP_EC_APAR;
    end
    else if (!mapped)
    begin
      ev_sev = dmap_pkg::SEV_SOFT;
      ev_code = `DMAP_EC_UNMAP;
    end
    else if (op_rdd && dsel.dbe)
    begin
      ev_sev = dmap_pkg::SEV_SOFT;
      ev_code = `DMAP_EC_DBE;
    end
    else if ((op_wrd || op_scr) && dbe_v != 4'h0)
    begin
      ev_sev = dmap_pkg::SEV_ADV; // corrupt line left for later readers
      ev_code = `DMAP_EC_DBE;
    end
    else if ((op_rdd && dsel.sbe) || ((op_wrd || op_scr) && sbe_v != 4'h0))
    begin
      ev_sev = dmap_pkg::SEV_ADV;
      ev_code = `DMAP_EC_SBE;
    end
  end
  wire logic err_rsp = par_bad || !mapped || (op_rdd && dsel.dbe);
  wire logic [63:0] err_word =
    {55'h0, err_code, err_over, err_multi, err_sev};

  // request sequencing: one operation in flight
  dmap_pkg::dmap_state_t next_st;
  always_comb
  begin
    case (st)
      dmap_pkg::ST_IDLE: next_st = csr_valid_i ? dmap_pkg::ST_EXEC : st;
      dmap_pkg::ST_EXEC: next_st = dmap_pkg::ST_DONE;
      dmap_pkg::ST_DONE: next_st = dmap_pkg::ST_IDLE;
      default:           next_st = dmap_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      st <= dmap_pkg::ST_IDLE;
      csr_ready_o <= 1'b1;
      req <= '0;
    end
    else if (ce_i)
    begin
      st <= next_st;
      csr_ready_o <= next_st == dmap_pkg::ST_IDLE;
      if (st == dmap_pkg::ST_IDLE && csr_valid_i)
        req <= csr_req_i;
    end
  end

  // response: error answers carry id and code but no data
  dmap_pkg::dmap_rsp_t next_rsp;
  always_comb
  begin
    next_rsp = '0;
    if (exec)
    begin
      next_rsp.valid = 1'b1;
      next_rsp.err = err_rsp;
      next_rsp.chip = err_rsp ? CHIP_ID : 3'h0;
      next_rsp.code = err_rsp ? ev_code : `DMAP_EC_NONE;
      if (!err_rsp && !wr)
        next_rsp.data = is_adr ? diag_address :
                        is_dat ? diag_data :
                        is_err ? err_word : 64'h0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      csr_rsp_o <= '0;
    else if (ce_i)
      csr_rsp_o <= next_rsp;
  end

  // diagnostic address register
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      diag_address <= `DMAP_ADDR_RST;
    else if (go && wr && is_adr)
      diag_address <= req.wdata & `DMAP_ADDR_MASK;
    else if (go && op_ini)
      diag_address[`DMAP_PGO_LSB +: `DMAP_PGO_W] <=
        pgo + `DMAP_PGO_W'(1);
  end

  // diagnostic data register
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      diag_data <= `DMAP_DATA_RST;
    else if (go && wr && is_dat)
      diag_data <= req.wdata;
    else if (go && op_rdd && !dsel.dbe)
      diag_data <= dsel.d;
    else if (go && op_rde)
      diag_data <= {56'h0, ecc_sel};
  end

  // line store updates
  always_ff @(posedge clk_i)
  begin
    if (go && op_wre)
      mem_e[sel] <= diag_data[7:0];
    if (go && op_ini)
      mem_tag[line] <= diag_data;
    for (int k = 0; k < 4; k++)
    begin
      if (go && op_ini)
      begin
        mem_d[{line, 2'(k)}] <= 64'h0;
        mem_e[{line, 2'(k)}] <= ecc_gen(64'h0);
      end
      else if (go && op_wrd && 2'(k) == lw)
      begin
        mem_d[sel] <= diag_data;
        mem_e[sel] <= ecc_gen(diag_data);
      end
      else if (go && (op_wrd || op_scr) && !dec[k].dbe)
      begin
        mem_d[{line, 2'(k)}] <= dec[k].d;
        mem_e[{line, 2'(k)}] <= ecc_gen(dec[k].d);
      end
    end
  end

  // error register: severity ordered, frozen by a hard error
  wire logic ev = exec && ev_sev != dmap_pkg::SEV_NONE && !frozen;
  wire logic up = ev && ev_sev > err_sev;
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      err_sev <= dmap_pkg::SEV_NONE;
      err_code <= `DMAP_EC_NONE;
      err_multi <= 1'b0;
      err_over <= 1'b0;
      frozen <= 1'b0;
      hard_error_o <= 1'b0;
    end
    else if (ce_i)
    begin
      // advisory events never reach this line
      hard_error_o <= ev && ev_sev == dmap_pkg::SEV_HARD;
      if (up)
      begin
        err_sev <= ev_sev;
        err_code <= ev_code;
        err_over <= err_sev != dmap_pkg::SEV_NONE;
      end
      else if (ev)
        err_multi <= 1'b1;
      else if (go && wr && is_err && !frozen)
      begin
        err_sev <= dmap_pkg::SEV_NONE;
        err_code <= `DMAP_EC_NONE;
        err_multi <= 1'b0;
        err_over <= 1'b0;
      end
      if (ev && ev_sev == dmap_pkg::SEV_HARD)
        frozen <= 1'b1;
    end
  end

  rdd_addr_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    go && op_rdd |=> $stable(diag_address))
    else $error("address changed by data read");
  wrd_keep_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    go && op_wrd |=> $stable(diag_address) && $stable(diag_data))
    else $error("registers changed by data write");
  wrd_ecc_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    go && op_wrd |=> !dsel.sbe && !dsel.dbe && dsel.d == diag_data)
    else $error("written longword does not read back clean");
  init_inc_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    go && op_ini |=> pgo == $past(pgo) + `DMAP_PGO_W'(1)
      && $stable(diag_data))
    else $error("init did not step to next line");
  rde_low_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    go && op_rde |=> diag_data == {56'h0, $past(ecc_sel)})
    else $error("ecc read not in low byte");
  freeze_err_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    frozen |=> $stable(err_word))
    else $error("error register changed while frozen");
  hard_sig_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    exec && par_bad && !frozen |=> hard_error_o ##1 !hard_error_o)
    else $error("hard error not signalled once");
  err_rsp_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    exec && op_rdd && dsel.dbe && !par_bad
      |=> csr_rsp_o.valid && csr_rsp_o.err
      && csr_rsp_o.code == `DMAP_EC_DBE)
    else $error("uncorrectable read not answered with error");
  no_data_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    csr_rsp_o.err |-> csr_rsp_o.data == 64'h0
      && csr_rsp_o.chip == CHIP_ID)
    else $error("error response carries data or wrong id");
  busy_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    st != dmap_pkg::ST_IDLE |-> !csr_ready_o)
    else $error("request taken while operation in flight");
endmodule
`default_nettype wire

// ===== test/dmap_cpu_model.sv
// processor model issuing csr loads and stores to the port
`timescale 1ns/10ps
`default_nettype none
module dmap_cpu_model (
  input  wire logic                clk_i,   // clock
  input  wire logic                ready_i, // request taken
  input  wire dmap_pkg::dmap_rsp_t rsp_i,   // response
  output logic                     valid_o, // request present
  output dmap_pkg::dmap_req_t      req_o    // request
);
  initial
  begin
    valid_o = 1'b0;
    req_o   = '0;
  end
  // one access; bad flips the address parity on purpose
  task automatic xfer(input logic w, input logic [7:0] o,
                      input logic [63:0] wd, input logic bad,
                      output dmap_pkg::dmap_rsp_t r);
    int n;
    @(posedge clk_i);
    valid_o <= 1'b1;
    req_o   <= '{w, o, wd, ^o ^ bad}; // bank sent as physical
    // look at ready off the edge, then hold until the taking edge
    #1;
    for (n = 0; n < 8 && ready_i !== 1'b1; n++)
    begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    valid_o <= 1'b0;
    req_o   <= ~req_o;
    r = '0;
    for (n = 0; n < 8; n++)
    begin
      @(posedge clk_i);
      #1;
      if (rsp_i.valid === 1'b1)
      begin
        r = rsp_i;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// ===== test/tb_diag_memory_access_port.sv
// self-checking bench for the diagnostic memory access port
`timescale 1ns/10ps
`default_nettype none
`include "dmap_consts.svh"
`define CHK(nm, e, g) cmp_count++; if ((g) !== (e)) begin \
  $display("BAD %s exp %h got %h", nm, e, g); miscompares++; end
module tb_diag_memory_access_port;
  localparam logic [63:0] LA  = 64'h0000_0000_0400_0060;
  localparam logic [2:0]  CID = 3'h5; // arbitrary value
  logic                clk_i;
  logic                reset_n_i;
  logic                csr_valid_i;
  logic                csr_ready_o;
  logic                hard_error_o;
  dmap_pkg::dmap_req_t csr_req_i;
  dmap_pkg::dmap_rsp_t csr_rsp_o;
  dmap_pkg::dmap_rsp_t r;
  logic [63:0]         a;
  int                  miscompares;
  int                  cmp_count;
  int                  cyc;
  int                  hard_cnt;
  dmap_top #(.CHIP_ID(CID)) u_dut (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .ce_i         (1'b1),
    .csr_valid_i  (csr_valid_i),
    .csr_req_i    (csr_req_i),
    .csr_ready_o  (csr_ready_o),
    .csr_rsp_o    (csr_rsp_o),
    .hard_error_o (hard_error_o)
  );
  dmap_cpu_model u_cpu (
    .clk_i   (clk_i),
    .ready_i (csr_ready_o),
    .rsp_i   (csr_rsp_o),
    .valid_o (csr_valid_i),
    .req_o   (csr_req_i)
  );
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard well above the expected few hundred cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (hard_error_o === 1'b1)
      hard_cnt++;
    if (cyc == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  task automatic wr(input logic [7:0] o, input logic [63:0] d);
    u_cpu.xfer(1'b1, o, d, 1'b0, r);
  endtask
  task automatic rd(input logic [7:0] o, output logic [63:0] d);
    u_cpu.xfer(1'b0, o, 64'h0, 1'b0, r);
    d = r.data;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] o,
                       input logic [63:0] e);
    logic [63:0] d;
    rd(o, d);
    `CHK(nm, e, d)
  endtask
  task automatic tend(input string nm);
    $display("test %s done, mismatches %0d", nm, miscompares);
  endtask
  initial
  begin
    int i;
    logic [63:0] p;
    reset_n_i = 1'b0;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdchk("addr_rst", `DMAP_OFS_ADDR, `DMAP_ADDR_RST);
    rdchk("data_rst", `DMAP_OFS_DATA, `DMAP_DATA_RST);
    wr(`DMAP_OFS_ADDR, '1);
    rdchk("addr_all", `DMAP_OFS_ADDR, `DMAP_ADDR_MASK);
    wr(`DMAP_OFS_DATA, 64'h0123_4567_89ab_cdef);
    rdchk("data", `DMAP_OFS_DATA, 64'h0123_4567_89ab_cdef);
    tend("registers");
    wr(`DMAP_OFS_ADDR, LA | 64'h18);
    wr(`DMAP_OFS_DATA, 64'h5a);
    wr(`DMAP_OFS_INIT, 64'h0);
    rd(`DMAP_OFS_ADDR, a);
    `CHK("init_addr", LA + 64'h20, a & ~64'h18)
    rdchk("init_data", `DMAP_OFS_DATA, 64'h5a);
    for (i = 0; i < 4; i++)
    begin
      wr(`DMAP_OFS_ADDR, LA | (i << 3));
      wr(`DMAP_OFS_DATA, '1);
      wr(`DMAP_OFS_RDDATA, 64'h0);
      rdchk("init_zero", `DMAP_OFS_DATA, 64'h0);
      wr(`DMAP_OFS_DATA, '1);
      wr(`DMAP_OFS_RDECC, 64'h0);
      rdchk("init_ecc", `DMAP_OFS_DATA, 64'h0);
    end
    tend("init");
    for (i = 0; i < 4; i++)
    begin
      p = 64'h1111_1111_1111_1111 * (i + 1);
      wr(`DMAP_OFS_ADDR, LA | (i << 3));
      wr(`DMAP_OFS_DATA, p);
      wr(`DMAP_OFS_WRDATA, 64'h0);
      rdchk("wr_data", `DMAP_OFS_DATA, p);
      rdchk("wr_addr", `DMAP_OFS_ADDR, LA | (i << 3));
    end
    for (i = 0; i < 4; i++)
    begin
      p = 64'h1111_1111_1111_1111 * (i + 1);
      wr(`DMAP_OFS_ADDR, LA | (i << 3));
      wr(`DMAP_OFS_DATA, 64'h0);
      wr(`DMAP_OFS_RDDATA, 64'h0);
      rdchk("rd_data", `DMAP_OFS_DATA, p);
      rdchk("rd_addr", `DMAP_OFS_ADDR, LA | (i << 3));
    end
    tend("longwords");
    wr(`DMAP_OFS_ADDR, LA);
    wr(`DMAP_OFS_DATA, 64'h0);
    wr(`DMAP_OFS_INIT, 64'h0);
    wr(`DMAP_OFS_ADDR, LA | 64'h8);
    wr(`DMAP_OFS_DATA, 64'hffff_ffff_ffff_ff01);
    wr(`DMAP_OFS_WRECC, 64'h0);
    wr(`DMAP_OFS_DATA, 64'h0);
    wr(`DMAP_OFS_RDECC, 64'h0);
    rdchk("wr_ecc", `DMAP_OFS_DATA, 64'h01);
    wr(`DMAP_OFS_ADDR, LA);
    wr(`DMAP_OFS_WRDATA, 64'h0);
    wr(`DMAP_OFS_ADDR, LA | 64'h8);
    wr(`DMAP_OFS_RDECC, 64'h0);
    rdchk("regen_ecc", `DMAP_OFS_DATA, 64'h0);
    tend("ecc");
    wr(`DMAP_OFS_ADDR, LA | 64'h10);
    wr(`DMAP_OFS_DATA, 64'h02);
    wr(`DMAP_OFS_WRECC, 64'h0);
    wr(`DMAP_OFS_ERRINFO, 64'h0);
    wr(`DMAP_OFS_SCRUB, 64'h0);
    `CHK("scrub_err", 1'b0, r.err)
    wr(`DMAP_OFS_RDECC, 64'h0);
    rdchk("scrub_ecc", `DMAP_OFS_DATA, 64'h0);
    rdchk("adv_log", `DMAP_OFS_ERRINFO, 64'h11);
    `CHK("adv_hard", 0, hard_cnt)
    tend("scrub");
    wr(`DMAP_OFS_ADDR, LA | 64'h18);
    wr(`DMAP_OFS_DATA, 64'h03);
    wr(`DMAP_OFS_WRECC, 64'h0);
    wr(`DMAP_OFS_DATA, 64'h77);
    wr(`DMAP_OFS_RDDATA, 64'h0);
    `CHK("dbe_rsp", {1'b1, CID, 5'h02}, {r.err, r.chip, r.code})
    `CHK("dbe_nodata", 64'h0, r.data)
    rdchk("dbe_keep", `DMAP_OFS_DATA, 64'h77);
    u_cpu.xfer(1'b0, 8'h48, 64'h0, 1'b0, r);
    `CHK("unmap_rsp", {1'b1, CID, 5'h04}, {r.err, r.chip, r.code})
    tend("responses");
    `CHK("no_hard", 0, hard_cnt)
    u_cpu.xfer(1'b1, `DMAP_OFS_DATA, 64'h99, 1'b1, r);
    `CHK("apar_rsp", {1'b1, 5'h03}, {r.err, r.code})
    rdchk("apar_keep", `DMAP_OFS_DATA, 64'h77);
    `CHK("hard_sig", 1, hard_cnt)
    rd(`DMAP_OFS_ERRINFO, a);
    `CHK("hard_log", 2'h3, a[1:0])
    wr(`DMAP_OFS_ERRINFO, 64'h0);
    rd(`DMAP_OFS_ERRINFO, a);
    `CHK("frozen", 2'h3, a[1:0])
    tend("hard");
    test_done();
  end
endmodule
`default_nettype wire
